//--- include/uvp_pkg.sv
/*
 * Package for the EPROM programmer/reader controller: pin bundle, command
 * codes, timing constants. Assumes a 100 MHz system clock.
 */
`default_nettype none
package uvp_pkg;
	localparam int ADDR_W = 11;
	localparam int DATA_W = 8;
	localparam int CLK_NS = 10;
	// Read access: slowest of address, chip-enable, output-enable delays
	localparam int ACCESS_NS = 450;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
	// Output float after output enable rises
	localparam int FLOAT_NS = 100;
	localparam int FLOAT_CYC = (FLOAT_NS + CLK_NS - 1) / CLK_NS;
	// Setup and hold around the program pulse
	localparam int SETUP_US = 2;
	localparam int SETUP_CYC = (SETUP_US * 1000 + CLK_NS - 1) / CLK_NS;
	// Program pulse: typical 50 ms, window 45 to 55 ms
	localparam int PULSE_MS = 50;
	localparam int PULSE_MIN_MS = 45;
	localparam int PULSE_MAX_MS = 55;
	localparam int PULSE_CYC = PULSE_MS * 100000;
	localparam int PULSE_MIN_CYC = (PULSE_MIN_MS * 1000000 + CLK_NS - 1) / CLK_NS;
	localparam int PULSE_MAX_CYC = PULSE_MAX_MS * 1000000 / CLK_NS;
	localparam logic [DATA_W-1:0] ERASED = 8'hFF;
	localparam int CNT_W = 23;

	typedef enum logic [1:0] {
		UVP_CMD_READ,
		UVP_CMD_PROGRAM,
		UVP_CMD_VERIFY
	} uvp_cmd_t;

	// Pins toward the memory
	typedef struct packed {
		logic [ADDR_W-1:0] byte_address_lines;
		logic              chip_enable_program_n;
		logic              output_enable_n;
		logic              vpp_high_en;
		logic [DATA_W-1:0] data_out;
		logic              data_oe;
	} uvp_pins_t;
endpackage : uvp_pkg
`default_nettype wire

//--- src/uvp_ctrl.sv
/*
 * Host-side controller driving a 2048 x 8 UV EPROM: reads, byte programming
 * with verify, and read-only verify. Assumes the memory pins are asynchronous
 * to sys_clk, the core supply is already up, and an external switch obeys
 * vpp_high_en for the 25V programming supply.
 * Limitation: a reset during a pulse drops the supply while chip enable stays high.
 */
// How it works
// RL1 - Read: both enables low, wait access time
// RL2 - Output enable high floats device data
// RL3 - Chip enable high is standby, floated
// RL4 - No extra wake time after standby
// RL5 - Erased bits read as one
// RL6 - Program zeros, any byte, any order
// RL7 - Zero low, one high on lines
// RL8 - 25V, enables set, pulse 45-55 ms
// RL9 - Never exceed maximum program pulse width
// RL10 - Verify: both low, read stored byte
// RL11 - Inhibit: no pulse keeps contents unchanged
// RL12 - Parallel devices, pulse selects data
// RL13 - Programming supply 5V for read modes
// RL14 - Counter-timed 50 ms, verify each byte
// RL15 - Supply order, programming supply via enable
`timescale 1ns/1ns
`default_nettype none
module uvp_ctrl
	import uvp_pkg::*;
#(
	parameter int PULSE_CYCLES = PULSE_CYC
) (
	input  wire logic                      sys_clk,
	input  wire logic                      reset,
	input  wire logic                      cmd_valid,
	input  wire uvp_pkg::uvp_cmd_t         cmd,
	input  wire logic [uvp_pkg::ADDR_W-1:0] cmd_addr,
	input  wire logic [uvp_pkg::DATA_W-1:0] cmd_data,
	input  wire logic [uvp_pkg::DATA_W-1:0] mem_data_in,
	output var uvp_pkg::uvp_pins_t          pins,
	output logic                           busy,
	output logic                           done,
	output logic [uvp_pkg::DATA_W-1:0]     rd_data,
	output logic                           verify_fail
);
	import uvp_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE, ST_VPP_UP, ST_SETUP, ST_PULSE, ST_HOLD,
		ST_ACCESS, ST_FLOAT, ST_VPP_DOWN
	} uvp_state_t;

	uvp_state_t            state;
	uvp_cmd_t              op;
	logic [CNT_W-1:0]      cnt;
	logic [DATA_W-1:0]     sync_a;
	logic [DATA_W-1:0]     sync_b;
	logic [DATA_W-1:0]     want;

	// Two-stage synchroniser on the data pins
	always_ff @(posedge sys_clk) begin
		sync_a <= mem_data_in;
		sync_b <= sync_a;
	end

	// Sequencer: each phase counts its own cycles
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state       <= ST_IDLE;
			op          <= UVP_CMD_READ;
			cnt         <= '0;
			want        <= ERASED;
			busy        <= 1'b0;
			done        <= 1'b0;
			// RL5 blank byte reads as all ones
			rd_data     <= ERASED;
			verify_fail <= 1'b0;
			// RL3 standby and floated bus when idle
			pins <= '{byte_address_lines: '0, chip_enable_program_n: 1'b1,
				output_enable_n: 1'b1, vpp_high_en: 1'b0, data_out: ERASED,
				data_oe: 1'b0};
		end else begin
			done <= 1'b0;
			cnt  <= cnt + 1'b1;
			case (state)
				ST_IDLE: begin
					cnt <= '0;
					if (cmd_valid) begin
						op   <= cmd;
						busy <= 1'b1;
						want <= cmd_data;
						// RL7 address held at true logic levels
						pins.byte_address_lines <= cmd_addr;
						pins.chip_enable_program_n <= 1'b0;
						if (cmd == UVP_CMD_PROGRAM) begin
							// RL15 programming supply via enable only
							pins.vpp_high_en <= 1'b1;
							state <= ST_VPP_UP;
						end else begin
							// RL1 both enables low for read
							pins.output_enable_n <= 1'b0;
							state <= ST_ACCESS;
						end
					end
				end
				ST_VPP_UP: begin
					// RL8 data driven with output enable high
					pins.data_out <= want;
					pins.data_oe  <= 1'b1;
					if (cnt == CNT_W'(SETUP_CYC - 1)) begin
						cnt   <= '0;
						state <= ST_SETUP;
					end
				end
				ST_SETUP: begin
					// RL6 zeros in want are written in one pulse
					if (cnt == CNT_W'(SETUP_CYC - 1)) begin
						cnt   <= '0;
						pins.chip_enable_program_n <= 1'b1;
						state <= ST_PULSE;
					end
				end
				ST_PULSE: begin
					// RL14 counter-timed pulse width
					// RL9 pulse ends before the maximum
					if (cnt == CNT_W'(PULSE_CYCLES - 1)) begin
						cnt   <= '0;
						pins.chip_enable_program_n <= 1'b0;
						state <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					// RL8 address, data and supply held after the pulse
					if (cnt == CNT_W'(SETUP_CYC - 1)) begin
						cnt   <= '0;
						pins.data_oe <= 1'b0;
						state <= ST_FLOAT;
					end
				end
				ST_FLOAT: begin
					// Device may still drive for the float time
					if (cnt == CNT_W'(FLOAT_CYC - 1)) begin
						cnt   <= '0;
						// RL10 verify with supply still high
						pins.output_enable_n <= 1'b0;
						state <= ST_ACCESS;
					end
				end
				ST_ACCESS: begin
					// RL4 same access wait after standby; plus sync delay
					if (cnt == CNT_W'(ACCESS_CYC + 2)) begin
						cnt     <= '0;
						rd_data <= sync_b;
						// RL14 check every programmed byte
						verify_fail <= (op != UVP_CMD_READ) && (sync_b != want);
						pins.output_enable_n       <= 1'b1;
						// RL11 after a program stay in inhibit, not standby:
						// chip enable rising at 25V would be a stray pulse
						pins.chip_enable_program_n <= op != UVP_CMD_PROGRAM;
						state <= (op == UVP_CMD_PROGRAM) ? ST_VPP_DOWN : ST_IDLE;
						busy  <= op == UVP_CMD_PROGRAM;
						done  <= op != UVP_CMD_PROGRAM;
					end
				end
				ST_VPP_DOWN: begin
					// RL13 supply back to 5V before next read
					pins.vpp_high_en <= 1'b0;
					if (cnt == CNT_W'(SETUP_CYC - 1)) begin
						cnt   <= '0;
						// RL3 standby only once the supply has settled
						pins.chip_enable_program_n <= 1'b1;
						busy  <= 1'b0;
						done  <= 1'b1;
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Helper: length of the current program pulse
	// Chip enable high at 25V is a pulse, whatever state caused it
	logic [CNT_W-1:0] pw_cnt;
	always_ff @(posedge sys_clk) begin
		if (reset || pins.chip_enable_program_n == 1'b0)
			pw_cnt <= '0;
		else if (pins.vpp_high_en)
			pw_cnt <= pw_cnt + 1'b1;
	end

	// Pin protocol checks, all on sys_clk and off during reset
	a_pulse_max_width: assert property (@(posedge sys_clk) disable iff (reset) // RL9
		pw_cnt <= CNT_W'(PULSE_MAX_CYC)) else $error("program pulse too long");
	a_pulse_min_width: assert property (@(posedge sys_clk) disable iff (reset) // RL8
		$fell(pins.chip_enable_program_n) && $past(pins.vpp_high_en) |->
		$past(pw_cnt) >= CNT_W'(PULSE_CYCLES - 1)) else $error("pulse too short");
	a_pulse_needs_vpp: assert property (@(posedge sys_clk) disable iff (reset) // RL8
		$rose(pins.chip_enable_program_n) && (pins.vpp_high_en || state == ST_PULSE) |->
		state == ST_PULSE && pins.vpp_high_en && pins.output_enable_n && pins.data_oe)
		else $error("pulse without program setup");
	a_pulse_data_stable: assert property (@(posedge sys_clk) disable iff (reset) // RL8
		state == ST_PULSE |-> $stable(pins.byte_address_lines) && $stable(pins.data_out)
		&& pins.data_oe) else $error("address or data moved during pulse");
	a_idle_standby: assert property (@(posedge sys_clk) disable iff (reset) // RL3
		state == ST_IDLE |-> pins.chip_enable_program_n && pins.output_enable_n
		&& !pins.vpp_high_en && !pins.data_oe) else $error("idle pins not in standby");
	a_verify_low_vpp: assert property (@(posedge sys_clk) disable iff (reset) // RL13
		op == UVP_CMD_VERIFY && state == ST_ACCESS |-> !pins.vpp_high_en)
		else $error("verify command with high supply");
	a_done_one_cycle: assert property (@(posedge sys_clk) disable iff (reset) // RL14
		done |=> !done) else $error("done longer than one cycle");
	a_no_bus_fight: assert property (@(posedge sys_clk) disable iff (reset) // RL2
		pins.data_oe |-> pins.output_enable_n) else $error("both sides drive data");
	a_read_low_vpp: assert property (@(posedge sys_clk) disable iff (reset) // RL13
		op == UVP_CMD_READ && state == ST_ACCESS |-> !pins.vpp_high_en)
		else $error("read with high supply");
	a_verify_result: assert property (@(posedge sys_clk) disable iff (reset) // RL14
		state == ST_ACCESS && cnt == CNT_W'(ACCESS_CYC + 2) && op == UVP_CMD_PROGRAM
		|=> verify_fail == ($past(sync_b) != want)) else $error("verify wrong");
	a_read_done: assert property (@(posedge sys_clk) disable iff (reset) // RL1
		state == ST_IDLE && cmd_valid && cmd == UVP_CMD_READ |=>
		!pins.output_enable_n && !pins.chip_enable_program_n ##(ACCESS_CYC + 3) done)
		else $error("read timing wrong");
	a_vpp_drop: assert property (@(posedge sys_clk) disable iff (reset) // RL15
		$fell(pins.vpp_high_en) |-> !pins.chip_enable_program_n && pins.output_enable_n
		&& !pins.data_oe)
		else $error("supply dropped mid program");
endmodule : uvp_ctrl
`default_nettype wire

//--- verification/uvp_eprom_model.sv
/* Behavioural 2048 x 8 EPROM for the bench.
   Assumes pins from uvp_ctrl; bus is the resolved data lines. */
`timescale 1ns/1ns
`default_nettype none
module uvp_eprom_model
	import uvp_pkg::*;
(
	input  wire uvp_pkg::uvp_pins_t    pins,
	output logic [uvp_pkg::DATA_W-1:0] bus
);
	logic [DATA_W-1:0] mem [2**ADDR_W];
	logic [DATA_W-1:0] dq;
	int                seq;

	initial begin
		foreach (mem[i])
			mem[i] = ERASED;
		dq = 8'h00;
		seq = 0;
	end

	always @(pins.chip_enable_program_n, pins.output_enable_n, pins.byte_address_lines) begin
		seq++;
		dq = ~dq; // Floating lines: no stale byte
		fork
			begin
				automatic int s = seq;
				#(ACCESS_NS - 5);
				if (s == seq && !pins.chip_enable_program_n && !pins.output_enable_n)
					dq = mem[pins.byte_address_lines];
			end
		join_none
	end

	// only a pulsed unit clears bits
	always @(posedge pins.chip_enable_program_n)
		if (pins.output_enable_n && pins.vpp_high_en && pins.data_oe)
			mem[pins.byte_address_lines] &= pins.data_out;

	// Host drive wins while it owns the lines
	assign bus = pins.data_oe ? pins.data_out : dq;
endmodule : uvp_eprom_model
`default_nettype wire

//--- verification/uvp_ctrl_bench.sv
/* Self-checking bench for uvp_ctrl.
   Assumes uvp_pkg and the EPROM model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module uvp_ctrl_bench;
	import uvp_pkg::*;
	localparam int PCYC = 10;
	logic              sys_clk, reset, cmd_valid;
	uvp_cmd_t          cmd;
	logic [ADDR_W-1:0] cmd_addr;
	logic [DATA_W-1:0] cmd_data, mem_data_in, rd_data;
	uvp_pins_t         pins;
	logic              busy, done, verify_fail;
	int                fails, n_compared, cyc, hi;

	uvp_ctrl #(.PULSE_CYCLES(PCYC)) uvp_ctrl_inst (.sys_clk(sys_clk), .reset(reset),
		.cmd_valid(cmd_valid), .cmd(cmd), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.mem_data_in(mem_data_in), .pins(pins), .busy(busy), .done(done),
		.rd_data(rd_data), .verify_fail(verify_fail));
	uvp_eprom_model uvp_eprom_model_inst (.pins(pins), .bus(mem_data_in));

	// Clock, 10 ns period
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Hang guard and program pulse tally
	always @(posedge sys_clk) begin
		cyc++;
		if (pins.vpp_high_en && pins.chip_enable_program_n && pins.data_oe)
			hi++;
		if (cyc == 20000) begin
			fails++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim

	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %s exp %h got %h", what, exp, got);
		end
	endtask : chk

	// One command, then wait for done; only the hang guard bounds the wait
	task automatic run(uvp_cmd_t c, logic [10:0] a, logic [7:0] d, output int n);
		@(posedge sys_clk);
		#1;
		cmd_valid = 1'b1;
		cmd = c;
		cmd_addr = a;
		cmd_data = d;
		@(posedge sys_clk);
		#1;
		cmd_valid = 1'b0;
		chk("busy up", 1'b1, busy);
		n = 0;
		while (done !== 1'b1) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk("busy down", 1'b0, busy);
	endtask : run

	task automatic t_erased();
		int n;
		chk("idle ce oe", 2'h3, {pins.chip_enable_program_n, pins.output_enable_n});
		run(UVP_CMD_READ, 11'h7FF, 8'h00, n);
		chk("erased", ERASED, rd_data);
		chk("rd lat", ACCESS_CYC + 3, n);
		chk("rd fail", 1'b0, verify_fail);
		$display("test erased done");
	endtask : t_erased

	task automatic t_program();
		int n;
		hi = 0;
		run(UVP_CMD_PROGRAM, 11'h123, 8'hA5, n);
		chk("pulse", PCYC, hi);
		chk("pgm fail", 1'b0, verify_fail);
		chk("vpp", 1'b0, pins.vpp_high_en);
		run(UVP_CMD_PROGRAM, 11'h123, 8'h5A, n);
		chk("zeros", 8'h00, rd_data);
		chk("repgm fail", 1'b1, verify_fail);
		$display("test program done");
	endtask : t_program

	task automatic t_verify();
		int n;
		run(UVP_CMD_PROGRAM, 11'h001, 8'hFE, n);
		run(UVP_CMD_READ, 11'h123, 8'h00, n);
		chk("inhibit", 8'h00, rd_data);
		run(UVP_CMD_VERIFY, 11'h001, 8'hFE, n);
		chk("vfy ok", 1'b0, verify_fail);
		run(UVP_CMD_VERIFY, 11'h001, 8'hFF, n);
		chk("vfy bad", 1'b1, verify_fail);
		chk("vfy lat", ACCESS_CYC + 3, n);
		$display("test verify done");
	endtask : t_verify

	// Main sequence
	initial begin
		reset = 1'b1;
		cmd_valid = 1'b0;
		cmd = UVP_CMD_READ;
		cmd_addr = 11'h000;
		cmd_data = 8'h00;
		repeat (4) @(posedge sys_clk);
		#1;
		reset = 1'b0;
		t_erased();
		t_program();
		t_verify();
		end_sim();
	end
endmodule : uvp_ctrl_bench
`default_nettype wire
